// >>> uwcr_regs.sv
//
// Contract
// [RULE_01] Writing one to control bit 0 starts reset.
// [RULE_02] Soft-reset bit stays set, self-clears when done.
// [RULE_03] Control bit 4 forces network framing globally.
// [RULE_04] Global network framing overrides per-endpoint fields.
// [RULE_05] Control bit 3 selects native interrupt path.
// [RULE_06] Control bit 1 enables clock-stop fast ack.
// [RULE_07] Status bit 0 mirrors VBUS drive output.
// [RULE_08] Revision word is fixed and read-only.
// [RULE_09] Emulation bits free-run, soft-stop, real-time select.
// [RULE_10] Mode field decodes transparent, network, comms, generic.
// [RULE_11] Receive fields at bits 17-16 through 29-28.
// [RULE_12] Transmit fields at bits 1-0 through 13-12.
// [RULE_13] Transparent mode marks every packet end-of-packet.
// [RULE_14] Reserved bits read zero, writes ignored.
//
// Purpose: Control and status register bank for a USB wrapper.
// Assumes: Single AHB-Lite master, whole-word single transfers.
// Notes:   Zero wait states; every output comes from a flip-flop.
`timescale 1ns/1ps

module uwcr_regs
#(
    parameter logic [31:0] REVISION   = uwcr_pkg::UWCR_REVISION_DEFAULT, // Arbitrary value.
    parameter int          RESET_CYC  = uwcr_pkg::UWCR_SOFT_RESET_CYC,
    parameter int          NUM_EP     = uwcr_pkg::UWCR_NUM_EP
)
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              reset_n,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Core-side status input.
    input  wire logic              vbus_drive_output,
    // Core-side controls.
    output logic                   module_reset_n,
    output logic                   clock_stop_fast_ack,
    output logic                   native_irq_path_select,
    output logic                   wrapper_irq_handler_en,
    output logic                   free_run_enable,
    output logic                   soft_stop_enable,
    output logic                   real_time_select,
    output logic [2*NUM_EP-1:0]    tx_ep_framing,
    output logic [2*NUM_EP-1:0]    rx_ep_framing,
    output logic [NUM_EP-1:0]      tx_ep_eop_per_packet,
    output logic [NUM_EP-1:0]      rx_ep_eop_per_packet
);
    import uwcr_pkg::*;

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    logic        wr_pend_r;  // Write data phase pending.
    logic [7:0]  addr_r;     // Latched address of the write.
    logic        rd_req;     // Read taken this cycle.
    logic        wr_req;     // Write taken this cycle.
    logic        wr_ctl;     // Write data phase hits control.
    logic        wr_emu;     // Write data phase hits emulation.
    logic        wr_mode;    // Write data phase hits mode.

    // Only NONSEQ or SEQ slots with the bus ready are taken; the size is
    // not decoded because every register is one whole aligned word.
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    assign wr_req = hsel && hready && htrans[1] && hwrite;
    assign wr_ctl  = wr_pend_r && (addr_r == UWCR_OFS_CONTROL);
    assign wr_emu  = wr_pend_r && (addr_r == UWCR_OFS_EMULATION);
    assign wr_mode = wr_pend_r && (addr_r == UWCR_OFS_MODE);

    // Latch the write address; data arrives in the following cycle.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end
        else
        begin
            wr_pend_r <= wr_req;
            addr_r    <= haddr;
        end
    end

    // With no wait states a read must be resolved in its address phase.
    // Never stall, always OKAY; unmapped addresses read zero.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register and soft reset sequencer
    // ------------------------------------------------------------------
    logic                  soft_reset_r;   // Soft-reset bit, visible to software.
    logic                  fast_ack_r;     // Clock-stop fast ack enable.
    logic                  native_irq_r;   // Native interrupt path select.
    logic                  global_net_r;   // Global network framing.
    logic [7:0]            rst_cnt_r;      // Module reset cycles remaining.

    // The bit stays set while the counter runs, so software can poll for
    // completion; a second write of one during reset just restarts it.
    // The bit clears in the same cycle the module reset is released, so a
    // poll that sees zero never catches the core still in reset. A write
    // of one in the very cycle the count ends wins over the clear.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            soft_reset_r <= UWCR_CTL_RESET[UWCR_CTL_SOFT_RESET_BIT];
            rst_cnt_r    <= 8'h00;
        end
        else if (wr_ctl && hwdata[UWCR_CTL_SOFT_RESET_BIT])
        begin
            soft_reset_r <= 1'b1;                              // [RULE_01]
            rst_cnt_r    <= 8'(RESET_CYC);
        end
        else if (rst_cnt_r != 8'h00)
        begin
            rst_cnt_r <= rst_cnt_r - 8'h01;                    // [RULE_02]
        end
        else
        begin
            soft_reset_r <= 1'b0;                              // [RULE_02]
        end
    end

    // Plain read/write control bits; bit 2 and above 4 are not stored.
    // Bit 0 is left alone here; only the sequencer above may clear it.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fast_ack_r   <= UWCR_CTL_RESET[UWCR_CTL_FAST_ACK_BIT];
            native_irq_r <= UWCR_CTL_RESET[UWCR_CTL_NATIVE_IRQ_BIT];
            global_net_r <= UWCR_CTL_RESET[UWCR_CTL_GLOBAL_NET_BIT];
        end
        else if (wr_ctl)
        begin
            fast_ack_r   <= hwdata[UWCR_CTL_FAST_ACK_BIT];     // [RULE_06]
            native_irq_r <= hwdata[UWCR_CTL_NATIVE_IRQ_BIT];   // [RULE_05]
            global_net_r <= hwdata[UWCR_CTL_GLOBAL_NET_BIT];   // [RULE_03]
        end
    end

    // ------------------------------------------------------------------
    // Emulation and mode registers
    // ------------------------------------------------------------------
    logic [2:0]  emu_r;   // Real-time select, soft stop, free run.
    logic [31:0] mode_r;  // Only the documented field bits are stored.
    logic [31:0] mode_mask;

    // Build the mask of writable mode bits from the field layout.
    // The layout holds four endpoints per direction; a larger NUM_EP
    // would run the receive fields past bit 31.
    always_comb
    begin
        mode_mask = 32'h0;
        for (int i = 0; i < NUM_EP; i++)
        begin
            mode_mask[UWCR_MODE_TX_BASE + i*UWCR_MODE_EP_STRIDE +: 2] = 2'h3; // [RULE_12]
            mode_mask[UWCR_MODE_RX_BASE + i*UWCR_MODE_EP_STRIDE +: 2] = 2'h3; // [RULE_11]
        end
    end

    // Emulation bits reset to free-run and soft-stop enabled.
    // Reserved emulation bits are not stored, so they read zero.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            emu_r <= UWCR_EMU_RESET;                            // [RULE_09]
        end
        else if (wr_emu)
        begin
            emu_r <= hwdata[2:0];                               // [RULE_09]
        end
    end

    // Reserved mode bits are masked off on write so they read zero.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_r <= UWCR_MODE_RESET;
        end
        else if (wr_mode)
        begin
            mode_r <= hwdata & mode_mask;                       // [RULE_14]
        end
    end

    // ------------------------------------------------------------------
    // Effective framing per endpoint
    // ------------------------------------------------------------------
    // Resolve a programmed field against the global override.
    // The register keeps the programmed value; only the result is forced.
    function automatic uwcr_frame_t eff_frame(input logic [1:0] field, input logic glob);
        uwcr_frame_t f;
        f = uwcr_frame_t'(field);                               // [RULE_10]
        if (glob)
        begin
            f = UWCR_FRAME_NETWORK;                             // [RULE_04]
        end
        return f;
    endfunction

    // One registered framing decode per endpoint and direction.
    // The core sees each mode one cycle after the register changes, as a
    // clean registered level rather than a decode of the bus data.
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : g_ep
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    tx_ep_framing[2*g +: 2]  <= 2'h0;
                    rx_ep_framing[2*g +: 2]  <= 2'h0;
                    tx_ep_eop_per_packet[g]  <= 1'b1;
                    rx_ep_eop_per_packet[g]  <= 1'b1;
                end
                else
                begin
                    tx_ep_framing[2*g +: 2] <= eff_frame(
                        mode_r[UWCR_MODE_TX_BASE + g*UWCR_MODE_EP_STRIDE +: 2], global_net_r);
                    rx_ep_framing[2*g +: 2] <= eff_frame(
                        mode_r[UWCR_MODE_RX_BASE + g*UWCR_MODE_EP_STRIDE +: 2], global_net_r);
                    tx_ep_eop_per_packet[g] <= eff_frame(                          // [RULE_13]
                        mode_r[UWCR_MODE_TX_BASE + g*UWCR_MODE_EP_STRIDE +: 2], global_net_r)
                        == UWCR_FRAME_TRANSPARENT;
                    rx_ep_eop_per_packet[g] <= eff_frame(                          // [RULE_13]
                        mode_r[UWCR_MODE_RX_BASE + g*UWCR_MODE_EP_STRIDE +: 2], global_net_r)
                        == UWCR_FRAME_TRANSPARENT;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Core-side control outputs
    // ------------------------------------------------------------------
    // Registered copies so every output leaves a flip-flop.
    // Exactly one interrupt path is live, since the handler enable is the
    // inverse of the native select.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            module_reset_n         <= 1'b1;
            clock_stop_fast_ack    <= 1'b0;
            native_irq_path_select <= 1'b0;
            wrapper_irq_handler_en <= 1'b1;
            free_run_enable        <= UWCR_EMU_RESET[UWCR_EMU_FREE_RUN_BIT];
            soft_stop_enable       <= UWCR_EMU_RESET[UWCR_EMU_SOFT_STOP_BIT];
            real_time_select       <= UWCR_EMU_RESET[UWCR_EMU_REAL_TIME_BIT];
        end
        else
        begin
            module_reset_n         <= !(soft_reset_r && rst_cnt_r != 8'h00); // [RULE_02]
            clock_stop_fast_ack    <= fast_ack_r;                  // [RULE_06]
            native_irq_path_select <= native_irq_r;                // [RULE_05]
            wrapper_irq_handler_en <= !native_irq_r;               // [RULE_05]
            free_run_enable        <= emu_r[UWCR_EMU_FREE_RUN_BIT];
            soft_stop_enable       <= emu_r[UWCR_EMU_SOFT_STOP_BIT];
            real_time_select       <= emu_r[UWCR_EMU_REAL_TIME_BIT];
        end
    end

    // ------------------------------------------------------------------
    // VBUS synchroniser and read path
    // ------------------------------------------------------------------
    logic [2:0]  vbus_sync_r; // Three-stage sampler of the pin.
    logic        vbus_r;      // Accepted level once stages 2 and 3 agree.
    logic [31:0] rd_data;     // Read mux output.

    // The first stage feeds only the second stage.
    // Waiting for the last two stages to agree also drops one-cycle glitches.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vbus_sync_r <= 3'h0;
            vbus_r      <= 1'b0;
        end
        else
        begin
            vbus_sync_r <= {vbus_sync_r[1:0], vbus_drive_output};
            if (vbus_sync_r[1] == vbus_sync_r[2])
            begin
                vbus_r <= vbus_sync_r[2];                       // [RULE_07]
            end
        end
    end

    // Read mux; anything not listed reads zero.
    // A read taken in the data phase of a write to the same register sees
    // the old value; software inserts one idle cycle to read back.
    always_comb
    begin
        rd_data = 32'h0;
        case (haddr)
            UWCR_OFS_REVISION:  rd_data = REVISION;             // [RULE_08]
            UWCR_OFS_CONTROL:   rd_data = {27'h0, global_net_r, native_irq_r, 1'b0,
                                           fast_ack_r, soft_reset_r};    // [RULE_14]
            UWCR_OFS_STATUS:    rd_data = {31'h0, vbus_r};      // [RULE_07]
            UWCR_OFS_EMULATION: rd_data = {29'h0, emu_r};
            UWCR_OFS_MODE:      rd_data = mode_r;
            default:            rd_data = 32'h0;
        endcase
    end

    // Read data is registered and held in the data phase.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hrdata <= 32'h0;
        end
        else if (rd_req)
        begin
            hrdata <= rd_data;
        end
    end

endmodule // uwcr_regs

// >>> uwcr_pkg.sv
// Purpose: Shared constants for the USB wrapper control register bank.
// Assumes: AHB-Lite slave with 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses within the bank.
package uwcr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] UWCR_OFS_REVISION  = 8'h00; // Module revision word.
    localparam logic [7:0] UWCR_OFS_CONTROL   = 8'h04; // Module control.
    localparam logic [7:0] UWCR_OFS_STATUS    = 8'h08; // Module status.
    localparam logic [7:0] UWCR_OFS_EMULATION = 8'h0C; // Emulation control.
    localparam logic [7:0] UWCR_OFS_MODE      = 8'h10; // Endpoint framing mode.

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int UWCR_CTL_SOFT_RESET_BIT = 0; // Self-clearing soft reset.
    localparam int UWCR_CTL_FAST_ACK_BIT   = 1; // Clock-stop fast ack enable.
    localparam int UWCR_CTL_NATIVE_IRQ_BIT = 3; // Native interrupt path select.
    localparam int UWCR_CTL_GLOBAL_NET_BIT = 4; // Global network framing.

    // ------------------------------------------------------------------
    // Status and emulation fields
    // ------------------------------------------------------------------
    localparam int UWCR_STS_VBUS_BIT      = 0; // Mirrors VBUS drive output.
    localparam int UWCR_EMU_FREE_RUN_BIT  = 0; // Free-run enable.
    localparam int UWCR_EMU_SOFT_STOP_BIT = 1; // Soft-stop enable.
    localparam int UWCR_EMU_REAL_TIME_BIT = 2; // Real-time select.

    // ------------------------------------------------------------------
    // Mode register layout
    // ------------------------------------------------------------------
    localparam int UWCR_MODE_TX_BASE   = 0;  // Transmit endpoint 1 field.
    localparam int UWCR_MODE_RX_BASE   = 16; // Receive endpoint 1 field.
    localparam int UWCR_MODE_EP_STRIDE = 4;  // Bits between endpoint fields.
    localparam int UWCR_NUM_EP         = 4;  // Endpoints per direction.

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  UWCR_EMU_RESET       = 3'h3;  // Free-run and soft-stop set.
    localparam logic [31:0] UWCR_MODE_RESET      = 32'h0; // All transparent.
    localparam logic [4:0]  UWCR_CTL_RESET       = 5'h0;  // Control bits clear.
    localparam logic [31:0] UWCR_REVISION_DEFAULT = 32'h0001_0000; // Arbitrary value.

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int UWCR_CLK_MHZ        = 100; // Register clock rate.
    localparam int UWCR_SOFT_RESET_NS  = 160; // Least module reset pulse.
    localparam int UWCR_SOFT_RESET_CYC = (UWCR_SOFT_RESET_NS * UWCR_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Framing modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        UWCR_FRAME_TRANSPARENT = 2'h0,
        UWCR_FRAME_NETWORK     = 2'h1,
        UWCR_FRAME_COMMS       = 2'h2,
        UWCR_FRAME_GENERIC_NET = 2'h3
    } uwcr_frame_t;

endpackage

// >>> uwcr_regs_asserts.sv
// Purpose: Concurrent checks on the port behaviour of the control register bank.
// Assumes: Zero wait states, one-cycle data phase, outputs one cycle after the register.
// Notes:   Helper flops track the bus data phase so checks can tie outputs to writes.
`timescale 1ns/1ps
module uwcr_regs_asserts
    import uwcr_pkg::*;
#(
    parameter logic [31:0] REVISION  = 32'h0000_0000,
    parameter int          RESET_CYC = 16
)
(
    // Clock, reset and bus.
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // Core-side controls.
    input wire logic        module_reset_n,
    input wire logic        clock_stop_fast_ack,
    input wire logic        native_irq_path_select,
    input wire logic        wrapper_irq_handler_en,
    input wire logic        free_run_enable,
    input wire logic        soft_stop_enable,
    input wire logic        real_time_select,
    input wire logic [7:0]  tx_ep_framing,
    input wire logic [7:0]  rx_ep_framing,
    input wire logic [3:0]  tx_ep_eop_per_packet,
    input wire logic [3:0]  rx_ep_eop_per_packet
);
    logic       dph_r;      // A data phase is in progress.
    logic       dph_wr_r;   // That data phase is a write.
    logic [7:0] dph_addr_r; // Address of that data phase.
    int         low_cnt_r;  // Cycles the module reset has been low.
    wire ctl_wr  = dph_r && dph_wr_r && (dph_addr_r == UWCR_OFS_CONTROL);
    wire rd_rev  = dph_r && !dph_wr_r && (dph_addr_r == UWCR_OFS_REVISION);
    wire rd_sts  = dph_r && !dph_wr_r && (dph_addr_r == UWCR_OFS_STATUS);
    wire sr_req  = ctl_wr && hwdata[0];
    // Track the data phase so checks see which register the bus touches.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dph_r      <= 1'b0;
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 8'h00;
        end
        else
        begin
            dph_r      <= hsel && hready && htrans[1];
            dph_wr_r   <= hwrite;
            dph_addr_r <= haddr;
        end
    end
    // Count the module reset pulse; a repetition would be too long to unroll.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            low_cnt_r <= 0;
        else if (!module_reset_n)
            low_cnt_r <= low_cnt_r + 1;
        else
            low_cnt_r <= 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_ctl_write; ctl_wr; endsequence
    sequence s_pulse_end; $rose(module_reset_n); endsequence
    a_ready_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
    a_irq_inverse: assert property (wrapper_irq_handler_en != native_irq_path_select)
        else $error("irq path outputs not inverse");
    a_eop_transparent: assert property (tx_ep_eop_per_packet[0] == (tx_ep_framing[1:0] == 2'h0)
        && rx_ep_eop_per_packet[3] == (rx_ep_framing[7:6] == 2'h0)) else $error("eop flag wrong");
    a_reset_length: assert property (s_pulse_end |-> low_cnt_r == RESET_CYC)
        else $error("module reset pulse length wrong");
    a_reset_cause: assert property ($fell(module_reset_n) |-> $past(sr_req, 1) || $past(sr_req, 2))
        else $error("module reset without soft reset write");
    a_global_force: assert property (s_ctl_write ##0 hwdata[4] |-> ##2 tx_ep_framing == 8'h55
        && rx_ep_framing == 8'h55) else $error("global framing not forced");
    a_fast_ack: assert property (s_ctl_write |-> ##2 clock_stop_fast_ack == $past(hwdata[1], 2))
        else $error("fast ack output wrong");
    a_native_sel: assert property (s_ctl_write |-> ##2 native_irq_path_select == $past(hwdata[3], 2))
        else $error("native irq select wrong");
    a_rev_fixed: assert property (rd_rev |-> hrdata == REVISION) else $error("revision word wrong");
    a_status_rsvd: assert property (rd_sts |-> hrdata[31:1] == 31'h0) else $error("status reserved set");
    a_emu_reset: assert property ($rose(reset_n) |-> free_run_enable && soft_stop_enable
        && !real_time_select) else $error("emulation reset values wrong");
endmodule // uwcr_regs_asserts

// >>> tb_top.sv
// Purpose: Self-checking bench for the control register bank over AHB-Lite.
// Assumes: Zero wait states; outputs settle one cycle after a register write.
// Notes:   Soft reset pulse shortened to keep polling brief.
`timescale 1ns/1ps
module tb_top;
    import uwcr_pkg::*;
    localparam logic [31:0] REV = 32'hA5C3_0F1E; // Arbitrary value.
    localparam int          RCY = 4;             // Short module reset pulse.
    logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, vbus = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, q;
    wire hready, hresp, mrst_n, fack, nat, wrp, frun, sstop, rts;
    wire [31:0] hrdata;
    wire [7:0]  txf, rxf;
    wire [3:0]  txe, rxe;
    int errors = 0, checks = 0, cyc = 0;
    always #5 clk = ~clk;
    uwcr_regs #(.REVISION(REV), .RESET_CYC(RCY)) i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .vbus_drive_output(vbus),
        .module_reset_n(mrst_n), .clock_stop_fast_ack(fack), .native_irq_path_select(nat),
        .wrapper_irq_handler_en(wrp), .free_run_enable(frun), .soft_stop_enable(sstop),
        .real_time_select(rts), .tx_ep_framing(txf), .rx_ep_framing(rxf),
        .tx_ep_eop_per_packet(txe), .rx_ep_eop_per_packet(rxe));
    // One whole-word transfer; the request holds until hready is seen high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Let the output flops catch up with the last register write.
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask
    task automatic t_reset_values();
        bus(0, UWCR_OFS_CONTROL, 0); chk("control", 32'h0, q);
        bus(0, UWCR_OFS_EMULATION, 0); chk("emulation", 32'h3, q);
        bus(0, UWCR_OFS_MODE, 0); chk("mode", 32'h0, q);
        bus(0, 8'h14, 0); chk("unmapped", 32'h0, q);
        chk("eop", 32'hFF, {rxe, txe});
    endtask
    task automatic t_control();
        bus(1, UWCR_OFS_CONTROL, 32'hFFFF_FFFA); settle();
        chk("mrst", 1, mrst_n);
        chk("outs", 32'h6, {fack, nat, wrp});
        chk("framing", 32'h5555, {rxf, txf});
        bus(0, UWCR_OFS_CONTROL, 0); chk("control", 32'h1A, q);
        bus(1, UWCR_OFS_MODE, 32'hFFFF_FFFF); settle();
        chk("forced", 32'h5555, {rxf, txf});
        bus(0, UWCR_OFS_MODE, 0); chk("mode", 32'h3333_3333, q);
        bus(1, UWCR_OFS_CONTROL, 0); settle();
        chk("own", 32'hFFFF, {rxf, txf});
        chk("outs", 32'h1, {fack, nat, wrp});
    endtask
    task automatic t_fields();
        bus(1, UWCR_OFS_MODE, 32'h3210_0123); settle();
        chk("tx", 32'h1B, txf);
        chk("rx", 32'hE4, rxf);
        chk("eop", 32'h18, {rxe, txe});
    endtask
    task automatic t_emu_rev();
        bus(1, UWCR_OFS_EMULATION, 32'hFFFF_FFF8); settle();
        chk("emu outs", 32'h0, {frun, sstop, rts});
        bus(1, UWCR_OFS_EMULATION, 32'h4); settle();
        chk("emu outs", 32'h1, {frun, sstop, rts});
        bus(0, UWCR_OFS_EMULATION, 0); chk("emulation", 32'h4, q);
        bus(1, UWCR_OFS_REVISION, 32'h0);
        bus(0, UWCR_OFS_REVISION, 0); chk("revision", REV, q);
    endtask
    task automatic t_vbus();
        vbus <= 1'b1; repeat (8) @(posedge clk);
        bus(0, UWCR_OFS_STATUS, 0); chk("status", 32'h1, q);
        vbus <= 1'b0; repeat (8) @(posedge clk);
        bus(0, UWCR_OFS_STATUS, 0); chk("status", 32'h0, q);
    endtask
    task automatic t_soft_reset();
        int n;
        bus(1, UWCR_OFS_CONTROL, 32'h1);
        bus(0, UWCR_OFS_CONTROL, 0); chk("busy", 32'h1, q[0]);
        chk("mrst", 0, mrst_n);
        n = 0;
        while (q[0] !== 1'b0 && n < 40)
        begin
            bus(0, UWCR_OFS_CONTROL, 0);
            n++;
        end
        chk("done", 32'h0, q[0]);
        chk("mrst", 1, mrst_n);
    endtask
    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Cut a hang short well beyond the expected run length.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            summarize();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_control();
        t_fields();
        t_emu_rev();
        t_vbus();
        t_soft_reset();
        summarize();
    end
endmodule // tb_top
bind uwcr_regs uwcr_regs_asserts #(.REVISION(REVISION), .RESET_CYC(RESET_CYC)) u_chk (.clk(clk),
    .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .module_reset_n(module_reset_n),
    .clock_stop_fast_ack(clock_stop_fast_ack), .native_irq_path_select(native_irq_path_select),
    .wrapper_irq_handler_en(wrapper_irq_handler_en), .free_run_enable(free_run_enable),
    .soft_stop_enable(soft_stop_enable), .real_time_select(real_time_select), .tx_ep_framing(tx_ep_framing),
    .rx_ep_framing(rx_ep_framing), .tx_ep_eop_per_packet(tx_ep_eop_per_packet),
    .rx_ep_eop_per_packet(rx_ep_eop_per_packet));
